/* rtl/urq_pkg.sv */
/*
  Shared constants of the ready-pin and interrupt-pin block: register offsets,
  field positions, reset values, trigger levels and timing counts.
  Assumes a 250 MHz system clock and a 32-bit APB register bus.
*/
package urq_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 6;
  localparam logic [5:0] FIFO_DEPTH = 6'h20;

  localparam logic [7:0] OFF_FIFO_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODEM_CTRL = 8'h04;
  localparam logic [7:0] OFF_LINE_STAT = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  localparam int FCR_FIFO_EN_BIT = 0;
  localparam int FCR_BLOCK_BIT = 3;
  localparam int FCR_TRIG_LSB = 6;
  localparam int MCR_IRQ_EN_BIT = 3;
  localparam int MCR_INT_TYPE_BIT = 5;
  localparam int LSR_THR_EMPTY_BIT = 5;
  localparam int LSR_TX_EMPTY_BIT = 6;
  localparam int CFG_WLEN_LSB = 0;
  localparam int CFG_EXT_CLK_BIT = 2;

  localparam int IRQ_W = 3;
  localparam int IRQ_RX_TRIG = 0;
  localparam int IRQ_RX_TMO = 1;
  localparam int IRQ_TX_EMPTY = 2;

  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h03;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  localparam logic [5:0] TRIG_LVL_0 = 6'h08;
  localparam logic [5:0] TRIG_LVL_1 = 6'h10;
  localparam logic [5:0] TRIG_LVL_2 = 6'h18;
  localparam logic [5:0] TRIG_LVL_3 = 6'h1c;

  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_PERIOD_NS = 68;
  localparam int OSC_HALF_RAW = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] OSC_HALF_CYCLES = 4'(OSC_HALF_RAW < 1 ? 1 : OSC_HALF_RAW);

  localparam int TMO_WORDS = 4;
  localparam int TMO_EXTRA_BITS = 12;
  localparam int TICKS_PER_BIT = 16;
  localparam int FRAME_OVERHEAD_BITS = 2;
  localparam int MIN_DATA_BITS = 5;
  localparam int TMO_W = 11;

  typedef enum logic [0:0] {
    URQ_RX_HIGH = 1'b0,
    URQ_RX_LOW = 1'b1
  } urq_rx_state_t;

  function automatic logic [5:0] urq_trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: urq_trig_level = TRIG_LVL_0;
      2'h1: urq_trig_level = TRIG_LVL_1;
      2'h2: urq_trig_level = TRIG_LVL_2;
      default: urq_trig_level = TRIG_LVL_3;
    endcase
  endfunction

  function automatic logic [TMO_W-1:0] urq_tmo_ticks(input logic [1:0] wlen);
    int bits;
    bits = TMO_WORDS * (MIN_DATA_BITS + int'(wlen) + FRAME_OVERHEAD_BITS) + TMO_EXTRA_BITS;
    urq_tmo_ticks = TMO_W'(bits * TICKS_PER_BIT);
  endfunction
endpackage

/* rtl/urq_sync2.sv */
/*
  Two-flop synchroniser for pin levels.
  Assumes the inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/10ps
module urq_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else if (ce) begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

/* rtl/urq_rx_timeout.sv */
/*
  Receive timeout timer counting baud ticks while the receive FIFO holds data.
  Assumes tick is a one-cycle pulse at 16 times the bit rate.
*/
`timescale 1ns/10ps
module urq_rx_timeout (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic tick,
  input wire logic armed,
  input wire logic restart,
  input wire logic [1:0] word_len,
  output logic fire
);
  logic [urq_pkg::TMO_W-1:0] cnt_reg;
  logic [urq_pkg::TMO_W-1:0] cnt_next;
  logic done_reg;
  logic done_next;
  logic fire_next;

  always_comb begin
    cnt_next = cnt_reg;
    done_next = done_reg;
    fire_next = 1'b0;
    // Fires once per quiet period; restarting on pops too keeps it off a busy host.
    if (!armed || restart) begin
      cnt_next = '0;
      done_next = 1'b0;
    end else if (tick && !done_reg) begin
      if (cnt_reg + 1'b1 >= urq_pkg::urq_tmo_ticks(word_len)) begin
        fire_next = 1'b1;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
      fire <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      fire <= fire_next;
    end
  end
endmodule

/* rtl/urq_ready_irq.sv */
/*
  Ready pins, interrupt pins, baud tick source and control registers of a
  byte-wide serial controller, reached over APB.
  Assumes FIFO storage and serial engines sit outside on the same clock and
  report fill counts, push and pop pulses and shift-register emptiness.
*/
`timescale 1ns/10ps
module urq_ready_irq (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_sel,
  input wire logic port_select_3,
  input wire logic port_select_1,
  input wire logic osc_in,
  output logic osc_out,
  output logic baud_tick,
  input wire logic [5:0] rx_count,
  input wire logic [5:0] tx_count,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tsr_empty,
  output logic rx_ready_n,
  output logic tx_ready_n,
  output logic shared_irq_out,
  output logic shared_irq_oe_n,
  output logic pc_irq_line_b,
  output logic pc_irq_line_b_oe_n,
  output logic pc_irq_line_c,
  output logic pc_irq_line_c_oe_n
);
  logic [3:0] pins_s;
  logic bus_std;
  logic sel3;
  logic sel1;
  logic osc_s;
  logic tmo_fire;

  urq_sync2 #(.W(4)) u_sync (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .d({bus_sel, port_select_3, port_select_1, osc_in}),
    .q(pins_s)
  );
  assign bus_std = pins_s[3];
  assign sel3 = pins_s[2];
  assign sel1 = pins_s[1];
  assign osc_s = pins_s[0];

  logic [7:0] fcr_reg, fcr_next, mcr_reg, mcr_next, cfg_reg, cfg_next;
  logic [2:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [31:0] rdata_next;
  logic rd_ok_reg, rd_ok_next, thr_empty_d_reg;
  logic wr_en, miss;
  logic [2:0] ev;
  logic [7:0] line_status_reg;
  logic blk_mode, thr_empty, irq_active;

  assign blk_mode = fcr_reg[urq_pkg::FCR_FIFO_EN_BIT] & fcr_reg[urq_pkg::FCR_BLOCK_BIT];
  assign thr_empty = (tx_count == 6'h00);
  always_comb begin
    line_status_reg = 8'h00;
    line_status_reg[urq_pkg::LSR_THR_EMPTY_BIT] = thr_empty;
    line_status_reg[urq_pkg::LSR_TX_EMPTY_BIT] = thr_empty & tsr_empty;
  end
  assign irq_active = |(stat_reg & mask_reg);

  always_comb begin
    miss = 1'b0;
    rdata_next = 32'h0000_0000;
    case (paddr)
      urq_pkg::OFF_FIFO_CTRL: rdata_next[7:0] = fcr_reg;
      urq_pkg::OFF_MODEM_CTRL: rdata_next[7:0] = mcr_reg;
      urq_pkg::OFF_LINE_STAT: rdata_next[7:0] = line_status_reg;
      urq_pkg::OFF_CONFIG: rdata_next[7:0] = cfg_reg;
      urq_pkg::OFF_IRQ_STAT: rdata_next[2:0] = stat_reg;
      urq_pkg::OFF_IRQ_MASK: rdata_next[2:0] = mask_reg;
      default: miss = 1'b1;
    endcase
  end

  // Data is captured in the setup cycle, so a plain access phase answers at once.
  assign pready = psel & penable & rd_ok_reg;
  assign pslverr = pready & miss;
  assign wr_en = pready & pwrite & ~miss;

  urq_pkg::urq_rx_state_t rx_state_reg, rx_state_next;
  logic rx_at_trig;
  assign rx_at_trig = (rx_count >= urq_pkg::urq_trig_level(fcr_reg[7:6])) && (rx_count != 6'h00);

  always_comb begin
    ev = 3'h0;
    ev[urq_pkg::IRQ_RX_TRIG] = (rx_state_reg == urq_pkg::URQ_RX_HIGH)
      && (rx_state_next == urq_pkg::URQ_RX_LOW);
    ev[urq_pkg::IRQ_RX_TMO] = tmo_fire;
    ev[urq_pkg::IRQ_TX_EMPTY] = thr_empty & ~thr_empty_d_reg;
  end

  always_comb begin
    fcr_next = fcr_reg;
    mcr_next = mcr_reg;
    cfg_next = cfg_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    rd_ok_next = psel & ~penable;
    if (psel & penable & ~rd_ok_reg) begin
      rd_ok_next = 1'b1;
    end
    if (wr_en) begin
      case (paddr)
        urq_pkg::OFF_FIFO_CTRL: fcr_next = pwdata[7:0];
        urq_pkg::OFF_MODEM_CTRL: mcr_next = pwdata[7:0];
        urq_pkg::OFF_CONFIG: cfg_next = pwdata[7:0];
        urq_pkg::OFF_IRQ_STAT: stat_next = stat_reg & ~pwdata[2:0];
        urq_pkg::OFF_IRQ_MASK: mask_next = pwdata[2:0];
        default: stat_next = stat_reg;
      endcase
    end
    // Set beats a same-cycle write-one clear so no event is lost.
    stat_next = stat_next | ev;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fcr_reg <= urq_pkg::FCR_RST;
      mcr_reg <= urq_pkg::MCR_RST;
      cfg_reg <= urq_pkg::CFG_RST;
      mask_reg <= urq_pkg::IRQ_MASK_RST;
      stat_reg <= 3'h0;
      rd_ok_reg <= 1'b0;
      thr_empty_d_reg <= 1'b1;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      fcr_reg <= fcr_next;
      mcr_reg <= mcr_next;
      cfg_reg <= cfg_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      rd_ok_reg <= rd_ok_next & ~pready;
      thr_empty_d_reg <= thr_empty;
      if (psel & ~pready) begin
        prdata <= rdata_next;
      end
    end
  end

  logic [3:0] osc_cnt_reg, osc_cnt_next;
  logic osc_phase_reg, osc_phase_next, osc_prev_reg, tick_next;

  always_comb begin
    osc_cnt_next = osc_cnt_reg;
    osc_phase_next = osc_phase_reg;
    tick_next = 1'b0;
    if (cfg_reg[urq_pkg::CFG_EXT_CLK_BIT]) begin
      tick_next = osc_s & ~osc_prev_reg;
      osc_cnt_next = 4'h0;
    end else if (osc_cnt_reg + 4'h1 >= urq_pkg::OSC_HALF_CYCLES) begin
      osc_cnt_next = 4'h0;
      osc_phase_next = ~osc_phase_reg;
      tick_next = ~osc_phase_reg;
    end else begin
      osc_cnt_next = osc_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      osc_cnt_reg <= 4'h0;
      osc_phase_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      baud_tick <= 1'b0;
    end else if (ce) begin
      osc_cnt_reg <= osc_cnt_next;
      osc_phase_reg <= osc_phase_next;
      osc_prev_reg <= osc_s;
      baud_tick <= tick_next;
    end
  end
  assign osc_out = osc_phase_reg;

  urq_rx_timeout u_tmo (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .tick(baud_tick),
    .armed(rx_count != 6'h00),
    .restart(rx_push | rx_pop),
    .word_len(cfg_reg[1:0]),
    .fire(tmo_fire)
  );

  logic rx_rdy_next, tx_rdy_next;
  logic sh_out_next, sh_oe_next, b_oe_next, c_oe_next;

  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      urq_pkg::URQ_RX_HIGH: begin
        if (blk_mode && (rx_at_trig || tmo_fire)) begin
          rx_state_next = urq_pkg::URQ_RX_LOW;
        end
      end
      urq_pkg::URQ_RX_LOW: begin
        // Held low through partial drains so the transfer engine empties the block.
        if (!blk_mode || rx_count == 6'h00) begin
          rx_state_next = urq_pkg::URQ_RX_HIGH;
        end
      end
      default: rx_state_next = urq_pkg::URQ_RX_HIGH;
    endcase
    if (blk_mode) begin
      rx_rdy_next = (rx_state_next == urq_pkg::URQ_RX_HIGH);
      tx_rdy_next = (tx_count == urq_pkg::FIFO_DEPTH);
    end else begin
      rx_rdy_next = (rx_count == 6'h00);
      tx_rdy_next = ~thr_empty;
    end
  end

  always_comb begin
    sh_out_next = irq_active;
    sh_oe_next = 1'b1;
    b_oe_next = 1'b1;
    c_oe_next = 1'b1;
    if (bus_std) begin
      sh_oe_next = mcr_reg[urq_pkg::MCR_INT_TYPE_BIT] & ~irq_active;
    end else if (!sel3) begin
      b_oe_next = sel1;
      c_oe_next = ~sel1;
    end else if (mcr_reg[urq_pkg::MCR_IRQ_EN_BIT]) begin
      sh_oe_next = mcr_reg[urq_pkg::MCR_INT_TYPE_BIT] & ~irq_active;
    end else begin
      sh_oe_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_state_reg <= urq_pkg::URQ_RX_HIGH;
      rx_ready_n <= 1'b1;
      tx_ready_n <= 1'b0;
      shared_irq_out <= 1'b0;
      shared_irq_oe_n <= 1'b1;
      pc_irq_line_b <= 1'b0;
      pc_irq_line_b_oe_n <= 1'b1;
      pc_irq_line_c <= 1'b0;
      pc_irq_line_c_oe_n <= 1'b1;
    end else if (ce) begin
      rx_state_reg <= rx_state_next;
      rx_ready_n <= rx_rdy_next;
      tx_ready_n <= tx_rdy_next;
      shared_irq_out <= sh_out_next;
      shared_irq_oe_n <= sh_oe_next;
      pc_irq_line_b <= irq_active;
      pc_irq_line_b_oe_n <= b_oe_next;
      pc_irq_line_c <= irq_active;
      pc_irq_line_c_oe_n <= c_oe_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_single_state: assert property (ce && !blk_mode |=> rx_state_reg == urq_pkg::URQ_RX_HIGH)
    else $error("receive state left idle outside block mode");
  chk_rx_single: assert property (ce && !blk_mode |=> rx_ready_n == $past(rx_count == 6'h00))
    else $error("receive ready wrong outside block mode");
  chk_tx_single: assert property (ce && !blk_mode |=> tx_ready_n == $past(tx_count != 6'h00))
    else $error("transmit ready wrong outside block mode");
  chk_rx_block_fall: assert property (ce && blk_mode && rx_at_trig |=> !rx_ready_n)
    else $error("receive ready did not fall at trigger");
  chk_tx_block: assert property (ce && blk_mode |=> tx_ready_n == $past(tx_count == 6'h20))
    else $error("transmit ready wrong in block mode");
  chk_lsr_read: assert property (ce && psel && !penable
    && paddr == urq_pkg::OFF_LINE_STAT |=> prdata[5] == $past(thr_empty))
    else $error("line status holding-empty bit wrong");
  chk_std_push: assert property (ce && bus_std && !mcr_reg[5] |=> !shared_irq_oe_n)
    else $error("standard interrupt pin not driven");
  chk_std_open: assert property (ce && bus_std && mcr_reg[5] && !irq_active
    |=> shared_irq_oe_n)
    else $error("open interrupt pin driven while idle");
  // The reset term keeps the edge that releases reset from judging reset values.
  chk_pc_sel_low: assert property (!srst && ce && !bus_std && !sel3
    |=> shared_irq_oe_n && (pc_irq_line_b_oe_n != pc_irq_line_c_oe_n))
    else $error("shared pin or line select wrong");
  chk_pc_disabled: assert property (ce && !bus_std && sel3 && !mcr_reg[3]
    |=> shared_irq_oe_n)
    else $error("shared pin driven while disabled");
  chk_pc_push: assert property (ce && !bus_std && sel3 && mcr_reg[3] && !mcr_reg[5]
    |=> !shared_irq_oe_n && shared_irq_out == $past(irq_active))
    else $error("shared pin level wrong");
  chk_pc_open: assert property (ce && !bus_std && sel3 && mcr_reg[3] && mcr_reg[5]
    && irq_active |=> !shared_irq_oe_n && shared_irq_out)
    else $error("shared pin not driven high when active");
  chk_tick_ext: assert property (ce && cfg_reg[2] && osc_s && !osc_prev_reg |=> baud_tick)
    else $error("external clock edge gave no tick");
  chk_tmo_sticky: assert property (ce && tmo_fire |=> stat_reg[1])
    else $error("timeout event lost");
  chk_rx_hold: assert property (rx_state_reg == urq_pkg::URQ_RX_LOW
    && ce && blk_mode && rx_count != 6'h00 |=> !rx_ready_n)
    else $error("receive ready rose before drain");

  cov_block_fall: cover property (blk_mode && rx_ready_n ##1 !rx_ready_n);
  cov_timeout: cover property (tmo_fire);
  cov_tx_full: cover property (blk_mode && tx_ready_n);
endmodule

/* bench/urq_fifo_model.sv */
/*
  Behavioural model of the FIFO storage and serial engines beside the block.
  Assumes the bench sets fill targets on the same clock as the block.
*/
`timescale 1ns/10ps
module urq_fifo_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic [5:0] rx_target,
  input wire logic [5:0] tx_target,
  output logic [5:0] rx_count,
  output logic [5:0] tx_count,
  output logic rx_push,
  output logic rx_pop
);
  // The receive side moves one byte a cycle so every step is a real push or pop.
  always_ff @(posedge clock) begin
    rx_push <= 1'b0;
    rx_pop <= 1'b0;
    if (srst) begin
      rx_count <= 6'h00;
      tx_count <= 6'h00;
    end else begin
      tx_count <= tx_target;
      if (rx_count < rx_target) begin
        rx_count <= rx_count + 6'h01;
        rx_push <= 1'b1;
      end else if (rx_count > rx_target) begin
        rx_count <= rx_count - 6'h01;
        rx_pop <= 1'b1;
      end
    end
  end
endmodule

/* bench/test_urq_ready_irq.sv */
/*
  Self-checking bench of the ready and interrupt pin block.
  Assumes the FIFO model beside it and a 250 MHz clock.
*/
`timescale 1ns/10ps
module test_urq_ready_irq;
  logic clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, bus_sel = 1'b1, ps3 = 1'b0, ps1 = 1'b0, osc_in = 1'b0;
  logic osc_out, baud_tick, rx_push, rx_pop, tsr_empty = 1'b1;
  logic ce = 1'b1;
  logic [5:0] rx_count, tx_count, rx_t = 6'h00, tx_t = 6'h00;
  logic rx_ready_n, tx_ready_n, sh_o, sh_oe_n, b_o, b_oe_n, c_o, c_oe_n;
  int n_fail = 0, check_count = 0, ticks;
  logic [3:0] tbl [6] = '{4'b0001, 4'b1001, 4'b1010, 4'b1010, 4'b0001, 4'b1001};
  logic [5:0] mode [6] = '{6'h20, 6'h28, 6'h00, 6'h10, 6'h12, 6'h1a};

  always #2 clock = ~clock;

  urq_fifo_model fifo_u (.clock(clock), .srst(srst), .rx_target(rx_t), .tx_target(tx_t),
    .rx_count(rx_count), .tx_count(tx_count), .rx_push(rx_push), .rx_pop(rx_pop));

  urq_ready_irq dut_u (.clock(clock), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_sel(bus_sel), .port_select_3(ps3), .port_select_1(ps1),
    .osc_in(osc_in), .osc_out(osc_out), .baud_tick(baud_tick), .rx_count(rx_count),
    .tx_count(tx_count), .rx_push(rx_push), .rx_pop(rx_pop), .tsr_empty(tsr_empty),
    .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n), .shared_irq_out(sh_o),
    .shared_irq_oe_n(sh_oe_n), .pc_irq_line_b(b_o), .pc_irq_line_b_oe_n(b_oe_n),
    .pc_irq_line_c(c_o), .pc_irq_line_c_oe_n(c_oe_n));

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request stands until pready is seen high; only the watchdog ends a stuck wait.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic t_regs;
    chk({rx_ready_n, tx_ready_n, sh_oe_n, b_oe_n, c_oe_n}, 32'h17);
    rd_chk(urq_pkg::OFF_FIFO_CTRL, 32'hff, 32'h00);
    rd_chk(urq_pkg::OFF_MODEM_CTRL, 32'hff, 32'h00);
    rd_chk(urq_pkg::OFF_CONFIG, 32'hff, 32'h03);
    rd_chk(urq_pkg::OFF_IRQ_MASK, 32'h7, 32'h0);
    apb(1'b1, 8'h40, 32'h5);
    chk(err, 1'b1);
    $display("test regs done");
  endtask

  task automatic t_plain;
    rx_t <= 6'h01;
    tx_t <= 6'h01;
    wait_cyc(5);
    chk({rx_ready_n, tx_ready_n}, 2'b01);
    rx_t <= 6'h00;
    tx_t <= 6'h00;
    wait_cyc(5);
    chk({rx_ready_n, tx_ready_n}, 2'b10);
    apb(1'b1, urq_pkg::OFF_FIFO_CTRL, 32'h01);
    rx_t <= 6'h02;
    tx_t <= 6'h02;
    wait_cyc(6);
    chk({rx_ready_n, tx_ready_n}, 2'b01);
    rd_chk(urq_pkg::OFF_LINE_STAT, 32'h60, 32'h00);
    rx_t <= 6'h00;
    tx_t <= 6'h00;
    wait_cyc(6);
    rd_chk(urq_pkg::OFF_LINE_STAT, 32'h60, 32'h60);
    tsr_empty <= 1'b0;
    rd_chk(urq_pkg::OFF_LINE_STAT, 32'h60, 32'h20);
    tsr_empty <= 1'b1;
    $display("test plain done");
  endtask

  task automatic t_block;
    apb(1'b1, urq_pkg::OFF_FIFO_CTRL, 32'h09);
    rx_t <= 6'h07;
    tx_t <= 6'h1f;
    wait_cyc(12);
    chk({rx_ready_n, tx_ready_n}, 2'b10);
    rx_t <= 6'h08;
    tx_t <= 6'h20;
    wait_cyc(4);
    chk({rx_ready_n, tx_ready_n}, 2'b01);
    rx_t <= 6'h01;
    wait_cyc(10);
    chk(rx_ready_n, 1'b0);
    rx_t <= 6'h00;
    tx_t <= 6'h00;
    wait_cyc(4);
    chk(rx_ready_n, 1'b1);
    apb(1'b1, urq_pkg::OFF_IRQ_STAT, 32'h7);
    $display("test block done");
  endtask

  task automatic t_irq;
    apb(1'b1, urq_pkg::OFF_IRQ_MASK, 32'h7);
    for (int i = 0; i < 6; i++) begin
      {bus_sel, ps3} <= mode[i][5:4];
      apb(1'b1, urq_pkg::OFF_MODEM_CTRL, {28'h0, mode[i][3:0]} << 2);
      apb(1'b1, urq_pkg::OFF_IRQ_STAT, 32'h7);
      wait_cyc(5);
      chk({sh_oe_n, sh_o & ~sh_oe_n}, tbl[i][3:2]);
      rx_t <= 6'h08;
      wait_cyc(14);
      chk({sh_oe_n, sh_o & ~sh_oe_n}, tbl[i][1:0]);
      if (i == 2) begin
        chk({b_oe_n, b_o, c_oe_n}, 3'b011);
        ps1 <= 1'b1;
        wait_cyc(5);
        chk({b_oe_n, c_oe_n, c_o}, 3'b101);
        ps1 <= 1'b0;
      end
      if (i == 0) begin
        apb(1'b1, urq_pkg::OFF_IRQ_MASK, 32'h0);
        wait_cyc(3);
        chk(sh_o, 1'b0);
        apb(1'b1, urq_pkg::OFF_IRQ_MASK, 32'h7);
      end
      rx_t <= 6'h00;
      wait_cyc(12);
    end
    apb(1'b1, urq_pkg::OFF_IRQ_STAT, 32'h7);
    rd_chk(urq_pkg::OFF_IRQ_STAT, 32'h7, 32'h0);
    $display("test irq done");
  endtask

  // Word length field 0 means five data bits.
  task automatic t_tmo;
    apb(1'b1, urq_pkg::OFF_CONFIG, 32'h00);
    rx_t <= 6'h01;
    ticks = 0;
    while (ticks < (4 * (5 + 2) + 12) * 16 - 10) begin
      @(posedge clock);
      ticks += int'(baud_tick);
    end
    chk(rx_ready_n, 1'b1);
    wait_cyc(16 * 24);
    chk(rx_ready_n, 1'b0);
    rd_chk(urq_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
    rx_t <= 6'h00;
    $display("test timeout done");
  endtask

  // The internal oscillator gives one tick per full period of two phases; the external pin one per rise.
  task automatic t_ext;
    int hi;
    hi = 0;
    ticks = 0;
    repeat (160) begin
      @(posedge clock);
      ticks += int'(baud_tick);
      hi += int'(osc_out);
    end
    chk(ticks, 160 / (2 * urq_pkg::OSC_HALF_CYCLES));
    chk(hi, 32'd80);
    apb(1'b1, urq_pkg::OFF_CONFIG, 32'h07);
    wait_cyc(4);
    ticks = 0;
    for (int k = 0; k < 200; k++) begin
      @(posedge clock);
      osc_in <= ((k / 10) % 2) == 1;
      ticks += int'(baud_tick);
    end
    chk(ticks, 32'd10);
    $display("test ext clock done");
  endtask

  // Clock enable low must freeze the pins even while the fill level moves.
  task automatic t_hold;
    apb(1'b1, urq_pkg::OFF_FIFO_CTRL, 32'h01);
    wait_cyc(2);
    ce <= 1'b0;
    rx_t <= 6'h01;
    wait_cyc(6);
    chk(rx_ready_n, 1'b1);
    ce <= 1'b1;
    wait_cyc(3);
    chk(rx_ready_n, 1'b0);
    rx_t <= 6'h00;
    wait_cyc(4);
    $display("test hold done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    wait_cyc(16);
    srst <= 1'b0;
    t_regs();
    t_plain();
    t_block();
    t_irq();
    t_tmo();
    t_ext();
    t_hold();
    wrap_up();
  end

  initial begin
    wait_cyc(40000);
    n_fail++;
    wrap_up();
  end
endmodule
